// File: hdl/cpss_ctrl.sv
/*
  Issue, stall, forwarding, serialization and interrupt recognition control.
  Assumes a decoder feeding classified instructions and a bus unit reporting waits.
*/
`timescale 1ns/1ps
module cpss_ctrl import cpss_pkg::*; (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_n,
  // Fetch and decode stream.
  input wire logic fetch_valid,
  input wire cpss_instr_type fetch_instr,
  input wire logic [CPSS_PC_W-1:0] fetch_pc,
  output logic fetch_ready_q,
  // Execute stage.
  output logic ex_valid_q,
  output cpss_instr_type ex_instr_q,
  output cpss_fwdsel_type ex_fwd_q,
  // Writeback stage.
  output logic wb_valid_q,
  output cpss_instr_type wb_instr_q,
  // Data bus and translation unit.
  input wire logic bus_wait,
  input wire logic bus_busy,
  input wire logic mmu_busy_i,
  input wire logic mmu_busy_d,
  output logic bus_req_ok_q,
  // Flush towards fetch.
  output logic flush_q,
  output logic [CPSS_PC_W-1:0] flush_pc_q,
  // External interrupt.
  input wire logic ext_int_n,
  input wire logic int_enable,
  input wire logic [CPSS_PC_W-1:0] state_in,
  output logic iack_q,
  output logic [CPSS_PC_W-1:0] save_pc_q,
  output logic [CPSS_PC_W-1:0] save_state_q,
  output logic syndrome_upd_q,
  output logic handler_fetch_q
);

  ////////////////////////////////////////////////////////////////////////////////
  // Declarations and input synchroniser.

  cpss_instr_type ir_q [2];
  logic [1:0] irv_q;
  cpss_instr_type ir_d [2];
  logic [1:0] irv_d;
  logic [CPSS_MC_W-1:0] ex_cnt_q;
  cpss_ist_type ist_q;
  logic irq_s;
  cpss_instr_type h;
  logic hv, ex_mem, ex_done, ex_free, stall, issue, flush_now;
  logic irq_want, ex_ls_pend, ex_intr, take_now, ack_now, abort;
  logic dep_csr, dep_ea;
  cpss_fwdsel_type fwd;

  cpss_sync #(.RST_VAL(CPSS_PIN_IDLE)) u_irq_sync (
    .clk(clk),
    .rst_n(rst_n),
    .d(ext_int_n),
    .q(irq_s)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Hazard detection.

  assign h = ir_q[0];
  assign hv = irv_q[0];
  assign ex_mem = ex_valid_q && cpss_is_mem(ex_instr_q.cls);
  // A memory access held by a wait state cannot finish.
  assign ex_done = ex_valid_q && (ex_cnt_q == CPSS_CNT_ZERO) && !(ex_mem && bus_wait);
  assign ex_free = !ex_valid_q || ex_done;

  always_comb begin
    dep_csr = 1'b0;
    dep_ea = 1'b0;
    fwd.a = FWD_RF;
    fwd.b = FWD_RF;
    // Serialized results are invisible until they complete.
    if (ex_valid_q && cpss_is_cser(ex_instr_q.cls) && ex_instr_q.wr_dst &&
        (ex_instr_q.dst == h.src_a || ex_instr_q.dst == h.src_b)) begin
      dep_csr = 1'b1;
    end
    if (wb_valid_q && cpss_is_cser(wb_instr_q.cls) && wb_instr_q.wr_dst &&
        (wb_instr_q.dst == h.src_a || wb_instr_q.dst == h.src_b)) begin
      dep_csr = 1'b1;
    end
    // Only an address operand from an in-flight load costs a bubble.
    if (cpss_is_mem(h.cls) && h.uses_ea && ex_valid_q && ex_instr_q.wr_dst &&
        (ex_instr_q.cls == CLS_LOAD || ex_instr_q.cls == CLS_LSM) &&
        ex_instr_q.dst == h.ea_src) begin
      dep_ea = 1'b1;
    end
    if (wb_valid_q && wb_instr_q.wr_dst && wb_instr_q.dst == h.src_a) begin
      fwd.a = FWD_WB;
    end
    if (wb_valid_q && wb_instr_q.wr_dst && wb_instr_q.dst == h.src_b) begin
      fwd.b = FWD_WB;
    end
    if (ex_valid_q && ex_instr_q.wr_dst && ex_instr_q.dst == h.src_a) begin
      fwd.a = FWD_EX;
    end
    if (ex_valid_q && ex_instr_q.wr_dst && ex_instr_q.dst == h.src_b) begin
      fwd.b = FWD_EX;
    end
  end

  always_comb begin
    stall = 1'b0;
    if (!ex_free || dep_csr || dep_ea) begin
      stall = 1'b1;
    end
    if (ist_q != IST_IDLE || irq_want) begin
      stall = 1'b1;
    end
    if ((ex_valid_q && (ex_instr_q.cls == CLS_SPR_DBG || ex_instr_q.cls == CLS_MSR)) ||
        (wb_valid_q && (wb_instr_q.cls == CLS_SPR_DBG || wb_instr_q.cls == CLS_MSR))) begin
      stall = 1'b1;
    end
    if ((ex_valid_q && (ex_instr_q.cls == CLS_MSYNC || ex_instr_q.cls == CLS_REFETCH)) ||
        (wb_valid_q && (wb_instr_q.cls == CLS_MSYNC || wb_instr_q.cls == CLS_REFETCH))) begin
      stall = 1'b1;
    end
    // Fast counter and link moves skip this, as do ALU, load, store, divide and load-multiple; the serialized classes wait to be next.
    if (cpss_is_cser(h.cls) && (ex_valid_q || wb_valid_q)) begin
      stall = 1'b1;
    end
    if (h.cls == CLS_MMU && (bus_busy || mmu_busy_i || mmu_busy_d)) begin
      stall = 1'b1;
    end
    if (h.spr_rd && ((ex_valid_q && ex_instr_q.spr_wr) || (wb_valid_q && wb_instr_q.spr_wr))) begin
      stall = 1'b1;
    end
  end

  assign issue = hv && !stall;

  ////////////////////////////////////////////////////////////////////////////////
  // Interrupt recognition.

  assign irq_want = !irq_s && int_enable && (ist_q == IST_IDLE);
  assign ex_ls_pend = ex_valid_q && (ex_instr_q.cls == CLS_LOAD ||
                      ex_instr_q.cls == CLS_STORE) && !ex_done;
  assign ex_intr = ex_valid_q && cpss_is_mc(ex_instr_q.cls) && !ex_done;
  assign take_now = irq_want && !ex_ls_pend;
  assign ack_now = take_now || (ist_q == IST_DRAIN && ex_done);
  assign abort = take_now && ex_intr;
  assign flush_now = ack_now || (wb_valid_q && wb_instr_q.cls == CLS_REFETCH);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ist_q <= IST_IDLE;
    end else begin
      unique case (ist_q)
        IST_IDLE: begin
          if (take_now) begin
            ist_q <= IST_ACK;
          end else if (irq_want) begin
            ist_q <= IST_DRAIN;
          end
        end
        IST_DRAIN: begin
          if (ex_done) begin
            ist_q <= IST_ACK;
          end
        end
        IST_ACK: begin
          ist_q <= IST_FETCH;
        end
        IST_FETCH: begin
          ist_q <= IST_RELEASE;
        end
        IST_RELEASE: begin
          // The request is level held, so wait for its release before rearming.
          if (irq_s) begin
            ist_q <= IST_IDLE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      iack_q <= 1'b0;
      syndrome_upd_q <= 1'b0;
      handler_fetch_q <= 1'b0;
      save_pc_q <= CPSS_PC_RST;
      save_state_q <= CPSS_PC_RST;
    end else begin
      iack_q <= ack_now;
      syndrome_upd_q <= ack_now;
      handler_fetch_q <= (ist_q == IST_ACK);
      if (ack_now) begin
        save_state_q <= state_in;
        if (abort) begin
          save_pc_q <= ex_instr_q.pc;
        end else if (hv) begin
          save_pc_q <= h.pc;
        end else begin
          save_pc_q <= fetch_pc;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Instruction register pair.

  // Two entries let the ready output be registered without losing throughput.
  always_comb begin
    ir_d[0] = ir_q[0];
    ir_d[1] = ir_q[1];
    irv_d = irv_q;
    if (flush_now || flush_q) begin
      irv_d = 2'h0;
    end else begin
      if (issue) begin
        ir_d[0] = ir_q[1];
        irv_d = {1'b0, irv_q[1]};
      end
      if (fetch_valid && fetch_ready_q) begin
        if (!irv_d[0]) begin
          ir_d[0] = fetch_instr;
          irv_d[0] = 1'b1;
        end else begin
          ir_d[1] = fetch_instr;
          irv_d[1] = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ir_q[0] <= '0;
      ir_q[1] <= '0;
      irv_q <= 2'h0;
      fetch_ready_q <= 1'b0;
    end else begin
      ir_q[0] <= ir_d[0];
      ir_q[1] <= ir_d[1];
      irv_q <= irv_d;
      fetch_ready_q <= !irv_d[1];
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Execute and writeback stages.

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ex_valid_q <= 1'b0;
      ex_instr_q <= '0;
      ex_fwd_q <= '0;
      ex_cnt_q <= CPSS_CNT_ZERO;
    end else if (abort) begin
      ex_valid_q <= 1'b0;
      ex_cnt_q <= CPSS_CNT_ZERO;
    end else if (issue) begin
      ex_valid_q <= 1'b1;
      ex_instr_q <= h;
      ex_fwd_q <= fwd;
      if (cpss_is_mc(h.cls)) begin
        ex_cnt_q <= (h.mc_len < CPSS_MC_MIN) ? CPSS_MC_MIN : h.mc_len;
      end else begin
        ex_cnt_q <= CPSS_CNT_ZERO;
      end
    end else if (ex_done) begin
      ex_valid_q <= 1'b0;
    end else if (ex_valid_q && ex_cnt_q != CPSS_CNT_ZERO && !(ex_mem && bus_wait)) begin
      ex_cnt_q <= ex_cnt_q - CPSS_CNT_ONE;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wb_valid_q <= 1'b0;
      wb_instr_q <= '0;
    end else begin
      wb_valid_q <= ex_done && !abort;
      if (ex_done) begin
        wb_instr_q <= ex_instr_q;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bus_req_ok_q <= 1'b1;
      flush_q <= 1'b0;
      flush_pc_q <= CPSS_PC_RST;
    end else begin
      // Translation moves always finish in one execute cycle, so this lifts at writeback.
      bus_req_ok_q <= !(issue && h.cls == CLS_MMU);
      flush_q <= flush_now;
      if (flush_now) begin
        flush_pc_q <= wb_instr_q.pc + CPSS_PC_STEP;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Assertions and covers.

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_mc_occupy: assert property (issue && cpss_is_mc(h.cls) && !abort
      |=> ex_valid_q && !ex_done) else $error("multi-cycle left execute at once");
  a_wb_order: assert property (ex_done && !abort |=> wb_valid_q &&
      wb_instr_q == $past(ex_instr_q)) else $error("writeback out of order");
  a_mc_blocks: assert property (ex_valid_q && ex_cnt_q != CPSS_CNT_ZERO
      |-> !issue) else $error("issue past busy multi-cycle");
  a_fwd_ex: assert property (issue && ex_valid_q && ex_instr_q.wr_dst &&
      ex_instr_q.dst == h.src_a |=> ex_fwd_q.a == FWD_EX) else $error("missed forward");
  a_ea_stall: assert property (hv && dep_ea |-> !issue) else $error("address hazard issued");
  a_wait_hold: assert property (ex_mem && bus_wait && !abort |-> !issue ##1 ex_valid_q)
      else $error("wait state did not stall");
  a_dbg_alone: assert property (issue && h.cls == CLS_SPR_DBG |-> !ex_valid_q && !wb_valid_q)
      else $error("debug move issued behind others");
  a_dbg_follow: assert property (issue && h.cls == CLS_SPR_DBG |=> !issue [*2])
      else $error("follower issued during debug move");
  a_msr_follow: assert property (issue && h.cls == CLS_MSR |=> !issue [*2])
      else $error("follower issued before state writeback");
  a_mmu_idle: assert property (issue && h.cls == CLS_MMU |-> !bus_busy && !mmu_busy_i &&
      !mmu_busy_d) else $error("translation move on busy bus");
  a_bus_holdoff: assert property (issue && h.cls == CLS_MMU |=> !bus_req_ok_q ##1 bus_req_ok_q)
      else $error("bus hold-off window wrong");
  a_spr_order: assert property (hv && h.spr_rd && ex_valid_q && ex_instr_q.spr_wr |-> !issue)
      else $error("special read passed write");
  a_drain_mem: assert property (ist_q == IST_DRAIN && !ex_done |=> !iack_q)
      else $error("handler started during access");
  a_abort_ex: assert property (abort |=> !ex_valid_q && iack_q && save_pc_q == $past(ex_instr_q.pc))
      else $error("abort did not clear execute");
  a_iack_seq: assert property (iack_q |-> flush_q ##1 (handler_fetch_q && !iack_q))
      else $error("acknowledge sequence wrong");
  a_refetch: assert property (wb_valid_q && wb_instr_q.cls == CLS_REFETCH |=> flush_q)
      else $error("no refetch flush");

  c_drain: cover property (ist_q == IST_DRAIN ##[1:20] iack_q);
  c_abort: cover property (abort);
  c_refetch: cover property (flush_q && !iack_q);
  c_mmu: cover property (issue && h.cls == CLS_MMU);

endmodule // cpss_ctrl

// File: hdl/cpss_pkg.sv
/*
  Shared types and constants of the core pipeline stall and serialize control.
  Assumes the decoder classifies each instruction into one of the classes below.
*/
package cpss_pkg;

  localparam int CPSS_REG_W = 5;
  localparam int CPSS_PC_W = 32;
  localparam int CPSS_MC_W = 4;
  localparam logic [CPSS_PC_W-1:0] CPSS_PC_STEP = 32'h0000_0004;
  localparam logic [CPSS_PC_W-1:0] CPSS_PC_RST = 32'h0000_0000;
  localparam logic [CPSS_MC_W-1:0] CPSS_MC_MIN = 4'h1;
  localparam logic [CPSS_MC_W-1:0] CPSS_CNT_ZERO = 4'h0;
  localparam logic [CPSS_MC_W-1:0] CPSS_CNT_ONE = 4'h1;
  localparam logic CPSS_PIN_IDLE = 1'b1;

  // Instruction classes as seen by the hazard logic.
  typedef enum logic [3:0] {
    CLS_ALU,
    CLS_LOAD,
    CLS_STORE,
    CLS_DIV,
    CLS_LSM,
    CLS_SPR_FAST,
    CLS_SPR_SYS,
    CLS_SPR_DBG,
    CLS_MSR,
    CLS_MMU,
    CLS_MSYNC,
    CLS_REFETCH
  } cpss_cls_type;

  typedef enum logic [1:0] {
    FWD_RF,
    FWD_EX,
    FWD_WB
  } cpss_fwd_type;

  typedef struct packed {
    cpss_cls_type cls;
    logic [CPSS_PC_W-1:0] pc;
    logic [CPSS_REG_W-1:0] dst;
    logic wr_dst;
    logic [CPSS_REG_W-1:0] src_a;
    logic [CPSS_REG_W-1:0] src_b;
    logic [CPSS_REG_W-1:0] ea_src;
    logic uses_ea;
    logic spr_wr;
    logic spr_rd;
    logic [CPSS_MC_W-1:0] mc_len;
  } cpss_instr_type;

  typedef struct packed {
    cpss_fwd_type a;
    cpss_fwd_type b;
  } cpss_fwdsel_type;

  typedef enum logic [2:0] {
    IST_IDLE,
    IST_DRAIN,
    IST_ACK,
    IST_FETCH,
    IST_RELEASE
  } cpss_ist_type;

  function automatic logic cpss_is_mem(input cpss_cls_type c);
    return (c == CLS_LOAD) || (c == CLS_STORE) || (c == CLS_LSM);
  endfunction

  function automatic logic cpss_is_mc(input cpss_cls_type c);
    return (c == CLS_DIV) || (c == CLS_LSM);
  endfunction

  // Classes that may only run when next to complete and never forward.
  function automatic logic cpss_is_cser(input cpss_cls_type c);
    return (c == CLS_SPR_SYS) || (c == CLS_SPR_DBG) || (c == CLS_MSR) ||
           (c == CLS_MMU) || (c == CLS_MSYNC) || (c == CLS_REFETCH);
  endfunction

endpackage

// File: hdl/cpss_sync.sv
/*
  Two flip-flop level synchroniser.
  Assumes its input is asynchronous to clk and only its output is used.
*/
`timescale 1ns/1ps
module cpss_sync import cpss_pkg::*; #(
  parameter logic RST_VAL = CPSS_PIN_IDLE
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_n,
  // Level in and out.
  input wire logic d,
  output logic q
);

  logic meta_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= RST_VAL;
      q <= RST_VAL;
    end else begin
      meta_q <= d;
      q <= meta_q;
    end
  end

endmodule // cpss_sync

// File: sim/cpss_partner.sv
/*
  Far-side model: data bus with a settable number of wait states, and an
  external interrupt source.
  Assumes the bench sets wait_cnt_n and pulses int_go off the rising edge.
*/
`timescale 1ns/1ps
module cpss_partner import cpss_pkg::*; (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_n,
  // Core side.
  input wire logic ex_valid_q,
  input wire cpss_instr_type ex_instr_q,
  input wire logic iack_q,
  // Bench controls.
  input wire logic [3:0] wait_cnt_n,
  input wire logic hold_busy,
  input wire logic int_go,
  // Bus and pin.
  output logic bus_wait,
  output logic bus_busy,
  output logic ext_int_n
);
  ////////////////////////////////////////////////////////////////////////////
  logic [3:0] wcnt_q;
  logic req_q;
  logic mem;

  assign mem = (ex_instr_q.cls == CLS_LOAD) || (ex_instr_q.cls == CLS_STORE) ||
               (ex_instr_q.cls == CLS_LSM);
  // Each access sees exactly wait_cnt_n wait cycles, then one done cycle.
  assign bus_wait = ex_valid_q && mem && (wcnt_q != wait_cnt_n);
  assign bus_busy = bus_wait || hold_busy;
  assign ext_int_n = !req_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) wcnt_q <= 4'h0;
    else wcnt_q <= bus_wait ? wcnt_q + 4'h1 : 4'h0;
  end

  // The request is held low until acknowledged, never dropped early.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) req_q <= 1'b0;
    else if (iack_q) req_q <= 1'b0;
    else if (int_go) req_q <= 1'b1;
  end
endmodule // cpss_partner

// File: sim/core_pipeline_stall_serialize_test.sv
/*
  Self-checking bench for the pipeline stall and serialize control.
  Assumes the far-side model and a 50 MHz clock; no registers or link clock.
*/
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin num_errors++; \
  $display("CHECK FAILED %s exp %0h got %0h", nm, e, g); end end
module core_pipeline_stall_serialize_test import cpss_pkg::*; ;
  ////////////////////////////////////////////////////////////////////////////
  logic clk = 1'b0, rst_n = 1'b0, fetch_valid = 1'b0, int_go = 1'b0, hold_busy = 1'b0;
  logic mmu_busy_i = 1'b0, mmu_busy_d = 1'b0, int_enable = 1'b1;
  logic bus_wait, bus_busy, ext_int_n, fetch_ready_q, ex_valid_q, wb_valid_q;
  logic bus_req_ok_q, flush_q, iack_q, syndrome_upd_q, handler_fetch_q;
  logic [3:0] wait_cnt_n = 4'h0;
  logic [31:0] pcn = 32'h0000_0100, state_in = 32'hA5A5_0F0F;
  logic [31:0] flush_pc_q, save_pc_q, save_state_q, a, b, c, d, e, f, g, h;
  cpss_instr_type fetch_instr = '0, ex_instr_q, wb_instr_q;
  cpss_fwdsel_type ex_fwd_q;
  int num_errors = 0, n_checks = 0, cyc = 0, iack_cyc = 0, hf_cyc = 0, syn_cyc = 0;
  int mmu_bad = 0, rel = 0;
  int ex_first[logic [31:0]], wb_cyc[logic [31:0]];
  cpss_fwd_type fwd_a[logic [31:0]];

  initial forever #10 clk = ~clk;

  cpss_ctrl cpss_ctrl_i (.clk(clk), .rst_n(rst_n), .fetch_valid(fetch_valid),
    .fetch_instr(fetch_instr), .fetch_pc(32'h0000_1000), .fetch_ready_q(fetch_ready_q),
    .ex_valid_q(ex_valid_q), .ex_instr_q(ex_instr_q), .ex_fwd_q(ex_fwd_q),
    .wb_valid_q(wb_valid_q), .wb_instr_q(wb_instr_q), .bus_wait(bus_wait),
    .bus_busy(bus_busy), .mmu_busy_i(mmu_busy_i), .mmu_busy_d(mmu_busy_d),
    .bus_req_ok_q(bus_req_ok_q), .flush_q(flush_q), .flush_pc_q(flush_pc_q),
    .ext_int_n(ext_int_n), .int_enable(int_enable), .state_in(state_in),
    .iack_q(iack_q), .save_pc_q(save_pc_q), .save_state_q(save_state_q),
    .syndrome_upd_q(syndrome_upd_q), .handler_fetch_q(handler_fetch_q));

  cpss_partner cpss_partner_i (.clk(clk), .rst_n(rst_n), .ex_valid_q(ex_valid_q),
    .ex_instr_q(ex_instr_q), .iack_q(iack_q), .wait_cnt_n(wait_cnt_n),
    .hold_busy(hold_busy), .int_go(int_go), .bus_wait(bus_wait),
    .bus_busy(bus_busy), .ext_int_n(ext_int_n));

  ////////////////////////////////////////////////////////////////////////////
  // Values read at the rising edge are those the design held over the cycle.
  always @(posedge clk) begin
    if (ex_valid_q && !ex_first.exists(ex_instr_q.pc)) begin
      ex_first[ex_instr_q.pc] = cyc;
      fwd_a[ex_instr_q.pc] = ex_fwd_q.a;
    end
    if (wb_valid_q) wb_cyc[wb_instr_q.pc] = cyc;
    if (iack_q) iack_cyc = cyc;
    if (syndrome_upd_q) syn_cyc = cyc;
    if (handler_fetch_q) hf_cyc = cyc;
    if (ex_valid_q && ex_instr_q.cls == CLS_MMU && bus_req_ok_q !== 1'b0) mmu_bad++;
    if (wb_valid_q && wb_instr_q.cls == CLS_MMU && bus_req_ok_q !== 1'b1) mmu_bad++;
    cyc++;
    if (cyc > 6000) begin
      num_errors++;
      conclude();
    end
  end

  task automatic send(input cpss_cls_type cl, output logic [31:0] p,
      input logic [4:0] dst = 5'h00, input logic [4:0] src = 5'h00,
      input logic [4:0] ea = 5'h00, input logic [3:0] m = 4'h0, input logic [1:0] sp = 2'h0);
    fetch_instr = '0;
    fetch_instr.cls = cl;
    fetch_instr.pc = pcn;
    fetch_instr.dst = dst;
    fetch_instr.wr_dst = (dst != 5'h00);
    fetch_instr.src_a = src;
    fetch_instr.ea_src = ea;
    fetch_instr.uses_ea = (ea != 5'h00);
    fetch_instr.mc_len = m;
    {fetch_instr.spr_wr, fetch_instr.spr_rd} = sp;
    p = pcn;
    pcn += CPSS_PC_STEP;
    fetch_valid = 1'b1;
    while (!(fetch_ready_q && !flush_q)) @(negedge clk);
    @(negedge clk);
  endtask

  task automatic idle(input int n);
    fetch_valid = 1'b0;
    repeat (n) @(negedge clk);
  endtask

  task automatic pulse_int();
    fetch_valid = 1'b0;
    for (int k = 0; k < 10 && !ex_valid_q; k++) @(negedge clk);
    int_go = 1'b1;
    @(negedge clk);
    int_go = 1'b0;
    idle(30);
  endtask

  task automatic t_multi();
    send(CLS_DIV, a, 5'h01, 5'h02, 5'h00, 4'h3);
    send(CLS_ALU, b, 5'h03, 5'h04);
    send(CLS_ALU, c, 5'h04, 5'h03);
    send(CLS_LSM, d, 5'h05, 5'h00, 5'h00, 4'h2);
    send(CLS_ALU, e, 5'h06);
    idle(20);
    `CHK("div_ex_len", 4, wb_cyc[a] - ex_first[a])
    `CHK("lsm_ex_len", 3, wb_cyc[d] - ex_first[d])
    `CHK("single_after_lsm", wb_cyc[d] + 1, wb_cyc[e])
    `CHK("wb_order", 1'b1, wb_cyc[a] < wb_cyc[b] && wb_cyc[b] < wb_cyc[c])
    `CHK("single_after_mc", wb_cyc[a] + 1, wb_cyc[b])
    `CHK("fwd_used", 1'b1, fwd_a[c] !== FWD_RF)
  endtask

  task automatic t_loads();
    send(CLS_LOAD, a, 5'h06, 5'h00, 5'h07);
    send(CLS_LOAD, b, 5'h08, 5'h00, 5'h09);
    send(CLS_ALU, c, 5'h0A, 5'h08);
    send(CLS_LOAD, d, 5'h0B, 5'h00, 5'h0C);
    send(CLS_STORE, e, 5'h00, 5'h00, 5'h0B);
    idle(20);
    `CHK("ld_overlap", 1, ex_first[b] - ex_first[a])
    `CHK("ld_use", 1, ex_first[c] - ex_first[b])
    `CHK("ea_dep", 2, ex_first[e] - ex_first[d])
    wait_cnt_n = 4'h2;
    send(CLS_LOAD, f, 5'h0D, 5'h00, 5'h07);
    send(CLS_LOAD, g, 5'h0E, 5'h00, 5'h09);
    idle(20);
    `CHK("wait_stall", 3, ex_first[g] - ex_first[f])
    wait_cnt_n = 4'h0;
  endtask

  task automatic t_spr();
    send(CLS_ALU, a, 5'h0D);
    send(CLS_SPR_FAST, b, 5'h0E, 5'h0D);
    send(CLS_ALU, c, 5'h0F, 5'h0E);
    send(CLS_DIV, d, 5'h10, 5'h00, 5'h00, 4'h2);
    send(CLS_SPR_DBG, e);
    send(CLS_ALU, f, 5'h11);
    send(CLS_MSR, g);
    send(CLS_ALU, h, 5'h12);
    idle(20);
    `CHK("fast_spr", 2, ex_first[c] - ex_first[a])
    `CHK("dbg_after_mc", 1'b1, ex_first[e] > wb_cyc[d])
    `CHK("after_dbg", 1'b1, ex_first[f] > wb_cyc[e])
    `CHK("after_state", 1'b1, ex_first[h] > wb_cyc[g])
    send(CLS_SPR_FAST, a, 5'h00, 5'h00, 5'h00, 4'h0, 2'h2);
    send(CLS_SPR_FAST, b, 5'h13, 5'h00, 5'h00, 4'h0, 2'h1);
    idle(20);
    `CHK("rd_after_wr", 1'b1, ex_first[b] > wb_cyc[a])
  endtask

  task automatic t_mmu();
    hold_busy = 1'b1;
    mmu_busy_i = 1'b1;
    mmu_busy_d = 1'b1;
    send(CLS_MMU, a);
    idle(4);
    `CHK("mmu_bus_busy", 1'b0, ex_valid_q)
    hold_busy = 1'b0;
    idle(4);
    `CHK("mmu_busy_i", 1'b0, ex_valid_q)
    mmu_busy_i = 1'b0;
    idle(4);
    `CHK("mmu_busy_d", 1'b0, ex_valid_q)
    mmu_busy_d = 1'b0;
    rel = cyc;
    idle(10);
    `CHK("mmu_issue", 1'b1, ex_first[a] > rel)
    `CHK("mmu_req_hold", 0, mmu_bad)
  endtask

  task automatic t_serial();
    send(CLS_ALU, a, 5'h14);
    send(CLS_SPR_SYS, b, 5'h15);
    send(CLS_ALU, c, 5'h16, 5'h15);
    send(CLS_MSYNC, d);
    send(CLS_ALU, e, 5'h17);
    idle(20);
    `CHK("sys_wait", 1'b1, ex_first[b] > wb_cyc[a])
    `CHK("no_fwd_ser", 1'b1, ex_first[c] > wb_cyc[b])
    `CHK("sync_block", 1'b1, ex_first[e] > wb_cyc[d])
    send(CLS_REFETCH, f);
    send(CLS_ALU, g, 5'h18);
    fetch_valid = 1'b0;
    for (int k = 0; k < 20 && !flush_q; k++) @(negedge clk);
    `CHK("refetch_flush", 1'b1, flush_q)
    `CHK("refetch_pc", f + CPSS_PC_STEP, flush_pc_q)
    idle(10);
    `CHK("refetch_drop", 1'b0, wb_cyc.exists(g))
  endtask

  task automatic t_int();
    wait_cnt_n = 4'h4;
    send(CLS_LOAD, a, 5'h19, 5'h00, 5'h07);
    pulse_int();
    `CHK("ld_before_ack", 1'b1, iack_cyc >= wb_cyc[a])
    `CHK("syndrome", iack_cyc, syn_cyc)
    `CHK("handler", iack_cyc + 1, hf_cyc)
    `CHK("save_state", state_in, save_state_q)
    `CHK("save_pc_idle", 32'h0000_1000, save_pc_q)
    wait_cnt_n = 4'h0;
    send(CLS_DIV, b, 5'h1A, 5'h00, 5'h00, 4'hF);
    pulse_int();
    `CHK("div_aborted", 1'b0, wb_cyc.exists(b))
    `CHK("abort_pc", b, save_pc_q)
    `CHK("abort_ack", 1'b1, iack_cyc > ex_first[b])
    `CHK("abort_early", 1'b1, iack_cyc - ex_first[b] < 10)
    // A masked request must stay pending until interrupts are enabled again.
    int_enable = 1'b0;
    rel = iack_cyc;
    pulse_int();
    `CHK("int_masked", rel, iack_cyc)
    int_enable = 1'b1;
    idle(10);
    `CHK("int_unmasked", 1'b1, iack_cyc > rel)
  endtask

  task automatic conclude();
    $display("errors %0d checks %0d", num_errors, n_checks);
    if (num_errors == 0 && n_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  initial begin
    repeat (2) @(negedge clk);
    rst_n = 1'b1;
    repeat (2) @(negedge clk);
    t_multi();
    t_loads();
    t_spr();
    t_mmu();
    t_serial();
    t_int();
    conclude();
  end
endmodule // core_pipeline_stall_serialize_test
